// ### hw/pse_pkg.sv
// shared constants and types of the protection and event supervisor
package pse_pkg;

  // ***********************************
  // measurement widths and nominals
  // ***********************************
  localparam int          MEAS_W     = 16;
  localparam logic [15:0] NOM_VOLT   = 16'h2710;
  localparam logic [15:0] NOM_CURR   = 16'h2710;
  localparam logic [15:0] NOM_POWR   = 16'h2710;
  localparam logic [31:0] PROT_NUM   = 32'h0000_000b;
  localparam logic [31:0] PROT_DEN   = 32'h0000_000a;
  localparam logic [15:0] PROT_MAX_V = 16'((32'(NOM_VOLT) * PROT_NUM) / PROT_DEN);
  localparam logic [15:0] PROT_MAX_I = 16'((32'(NOM_CURR) * PROT_NUM) / PROT_DEN);
  localparam logic [15:0] PROT_MAX_P = 16'((32'(NOM_POWR) * PROT_NUM) / PROT_DEN);

  // ***********************************
  // alarm and event indices
  // ***********************************
  localparam int NUM_PROT  = 3;
  localparam int NUM_LATCH = 5;
  localparam int NUM_ALM   = 6;
  localparam int NUM_EVT   = 5;
  localparam int ALM_OVP   = 0;
  localparam int ALM_OCP   = 1;
  localparam int ALM_OPP   = 2;
  localparam int ALM_ACF   = 3;
  localparam int ALM_OTMP  = 4;
  localparam int ALM_LINK  = 5;
  localparam int EVT_LOW_V  = 0;
  localparam int EVT_HIGH_V = 1;
  localparam int EVT_LOW_I  = 2;
  localparam int EVT_HIGH_I = 3;
  localparam int EVT_HIGH_P = 4;

  // ***********************************
  // configuration select codes
  // ***********************************
  localparam logic [3:0] CFG_SEL_PROT_V = 4'h0;
  localparam logic [3:0] CFG_SEL_PROT_I = 4'h1;
  localparam logic [3:0] CFG_SEL_PROT_P = 4'h2;
  localparam logic [3:0] CFG_SEL_EVT0   = 4'h3;
  localparam logic [3:0] CFG_SEL_LAST   = 4'h7;

  // ***********************************
  // profile store layout
  // ***********************************
  localparam int          MEM_AW      = 5;
  localparam int          MEM_DW      = 18;
  localparam int          MEM_DEPTH   = 25;
  localparam logic [2:0]  PROF_DEFAULT = 3'h0;
  localparam logic [2:0]  PROF_LAST    = 3'h5;
  localparam logic [2:0]  STEP_LAST    = 3'h4;
  localparam logic [2:0]  STEP_LOAD_END = 3'h5;
  localparam logic [15:0] EVT_THR_RST  = 16'h0000;

  typedef enum logic [1:0] {
    PSE_ACT_NONE    = 2'b00,
    PSE_ACT_SIGNAL  = 2'b01,
    PSE_ACT_WARNING = 2'b10,
    PSE_ACT_ALARM   = 2'b11
  } pse_act_e;

  typedef enum logic [1:0] {
    PSE_LT_IDLE  = 2'b00,
    PSE_LT_UNACK = 2'b01,
    PSE_LT_HELD  = 2'b10
  } pse_latch_e;

  typedef enum logic [1:0] {
    PSE_PF_IDLE = 2'b00,
    PSE_PF_SAVE = 2'b01,
    PSE_PF_LOAD = 2'b10
  } pse_prof_e;

endpackage : pse_pkg

// ### hw/pse_alarm_latch.sv
// one device alarm latch with acknowledge handling
`timescale 1ns/1ns
module pse_alarm_latch
  import pse_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic cond,
  input  wire logic ack,
  output logic      shown_q,
  output logic      wait_ack_q
);

  pse_latch_e state_q;
  pse_latch_e state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PSE_LT_IDLE: begin
        if (cond) begin
          state_d = PSE_LT_UNACK;
        end
      end
      PSE_LT_UNACK: begin
        if (ack) begin
          state_d = cond ? PSE_LT_HELD : PSE_LT_IDLE;
        end
      end
      PSE_LT_HELD: begin
        if (!cond) begin
          state_d = PSE_LT_UNACK;
        end
      end
      default: begin
        state_d = PSE_LT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= PSE_LT_IDLE;
      shown_q    <= 1'b0;
      wait_ack_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      shown_q    <= (state_d != PSE_LT_IDLE);
      wait_ack_q <= (state_d == PSE_LT_UNACK);
    end
  end

  chk_latch_hold: assert property (@(posedge clk) disable iff (!arst_n)
    shown_q && !ack |=> shown_q) else $error("alarm dropped without ack");

  chk_ack_clears: assert property (@(posedge clk) disable iff (!arst_n)
    wait_ack_q && ack && !cond |=> !shown_q) else $error("acked alarm not cleared");

  chk_ack_persist: assert property (@(posedge clk) disable iff (!arst_n)
    wait_ack_q && ack && cond |=> shown_q && !wait_ack_q)
    else $error("persisting alarm mishandled");

  chk_reack_needed: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == PSE_LT_HELD && !cond |=> shown_q && wait_ack_q)
    else $error("fresh ack not requested");

endmodule : pse_alarm_latch

// ### hw/pse_profile_mem.sv
// event configuration store for the user profiles
`timescale 1ns/1ns
module pse_profile_mem
  import pse_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              we,
  input  wire logic [MEM_AW-1:0] waddr,
  input  wire logic [MEM_DW-1:0] wdata,
  input  wire logic [MEM_AW-1:0] raddr,
  output logic      [MEM_DW-1:0] rdata_q
);

  logic [MEM_DW-1:0] mem_q [MEM_DEPTH];

  // user profiles start equal to the default: thresholds zero, action none
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[raddr];
    end
  end

endmodule : pse_profile_mem

// ### hw/pse_supervisor.sv
// protection alarm and user event supervisor of the dc load input
// ************************************************************
// Notes on behaviour
// - each device alarm stays pending until acknowledged, condition or not
// - ack clears the alarm indication only if the condition is already gone
// - ack during a persisting condition keeps indication; fresh ack needed later
// - voltage reaching its threshold alarms, drops input, flags analog output
// - current reaching its threshold alarms and drops the input
// - power reaching its threshold alarms and drops the input
// - protection thresholds reset to 110 percent of nominal
// - ac supply failure alarms and drops the input, fixed
// - overtemperature alarms, drops the input and flags analog output
// - initialised master loses a slave or sees uninitialised slave: link alarm
// - link alarm clears only by disabling or reinitialising the link
// - acoustic signal only when the sound setting is on
// - user event actions reset to disabled
// - user events only while input is on; alarms always
// - five events, own threshold and own action each
// - low voltage event when voltage below threshold
// - high voltage event when voltage above threshold
// - low current event when current below threshold
// - high current event when current above threshold
// - high power event when power above threshold
// - event with alarm action drops the input
// - event configuration is saved and loaded per profile
// - signal posts message, warning adds warning, alarm adds alarm and sound
// ************************************************************
`timescale 1ns/1ns
module pse_supervisor
  import pse_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              meas_valid,
  input  wire logic [MEAS_W-1:0] meas_voltage,
  input  wire logic [MEAS_W-1:0] meas_current,
  input  wire logic [MEAS_W-1:0] meas_power,
  input  wire logic              ac_fail,
  input  wire logic              temp_over,
  input  wire logic              ms_enabled,
  input  wire logic              ms_initialised,
  input  wire logic              ms_slave_lost,
  input  wire logic              ms_slave_uninit,
  input  wire logic              ms_reinit,
  input  wire logic              alarm_ack,
  input  wire logic              sound_enable,
  input  wire logic              dc_on_req,
  input  wire logic              dc_off_req,
  input  wire logic              cfg_wr,
  input  wire logic [3:0]        cfg_sel,
  input  wire logic [MEAS_W-1:0] cfg_value,
  input  wire logic [1:0]        cfg_action,
  input  wire logic              profile_save,
  input  wire logic              profile_load,
  input  wire logic [2:0]        profile_idx,
  output logic                   dc_input_on_q,
  output logic [NUM_ALM-1:0]     alarm_shown,
  output logic [NUM_LATCH-1:0]   alarm_unacked,
  output logic                   analog_alarm_q,
  output logic [NUM_EVT-1:0]     evt_hit_q,
  output logic [NUM_EVT-1:0]     evt_msg_q,
  output logic                   warning_ind_q,
  output logic                   evt_alarm_ind_q,
  output logic                   beep_q,
  output logic                   profile_busy_q
);

  // ***********************************
  // decode helpers
  // ***********************************
  function automatic logic [MEAS_W-1:0] clamp(input logic [MEAS_W-1:0] v, input logic [MEAS_W-1:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction : clamp

  function automatic logic evt_cmp(input int k, input logic [MEAS_W-1:0] v, input logic [MEAS_W-1:0] i,
                                   input logic [MEAS_W-1:0] p, input logic [MEAS_W-1:0] thr);
    case (k)
      EVT_LOW_V:  evt_cmp = v < thr;
      EVT_HIGH_V: evt_cmp = v > thr;
      EVT_LOW_I:  evt_cmp = i < thr;
      EVT_HIGH_I: evt_cmp = i > thr;
      default:    evt_cmp = p > thr;
    endcase
  endfunction : evt_cmp

  function automatic logic [MEAS_W-1:0] evt_limit(input int k);
    case (k)
      EVT_LOW_V, EVT_HIGH_V: evt_limit = NOM_VOLT;
      EVT_LOW_I, EVT_HIGH_I: evt_limit = NOM_CURR;
      default:               evt_limit = NOM_POWR;
    endcase
  endfunction : evt_limit

  function automatic logic [MEM_AW-1:0] prof_base(input logic [2:0] idx);
    prof_base = MEM_AW'(MEM_AW'(idx - 3'h1) * MEM_AW'(3'h5));
  endfunction : prof_base

  // ***********************************
  // state
  // ***********************************
  logic [MEAS_W-1:0]    prot_thr_q [NUM_PROT];
  logic [MEAS_W-1:0]    evt_thr_q  [NUM_EVT];
  pse_act_e             evt_act_q  [NUM_EVT];
  logic [NUM_PROT-1:0]  prot_hit_q;
  logic [NUM_LATCH-1:0] alm_cond;
  logic [NUM_LATCH-1:0] latch_shown;
  logic                 link_cond;
  logic                 link_alarm_q;
  logic [NUM_EVT-1:0]   evt_alm_hit;
  logic [NUM_EVT-1:0]   evt_warn_hit;
  logic [NUM_EVT-1:0]   evt_any_hit;
  logic                 trip;
  pse_prof_e            pf_state_q;
  logic [2:0]           pf_step_q;
  logic [2:0]           pf_idx_q;
  logic                 mem_we;
  logic [MEM_AW-1:0]    mem_waddr;
  logic [MEM_DW-1:0]    mem_wdata;
  logic [MEM_AW-1:0]    mem_raddr;
  logic [MEM_DW-1:0]    mem_rdata_q;
  logic [2:0]           load_slot;

  // ***********************************
  // protection compares
  // ***********************************
  // compare on update
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prot_hit_q <= '0;
    end else if (meas_valid) begin
      prot_hit_q[ALM_OVP] <= meas_voltage >= prot_thr_q[ALM_OVP];
      prot_hit_q[ALM_OCP] <= meas_current >= prot_thr_q[ALM_OCP];
      prot_hit_q[ALM_OPP] <= meas_power >= prot_thr_q[ALM_OPP];
    end
  end

  assign alm_cond = {temp_over, ac_fail, prot_hit_q};

  generate
    for (genvar a = 0; a < NUM_LATCH; a++) begin : g_latch
      pse_alarm_latch u_latch (
        .clk        (clk),
        .arst_n     (arst_n),
        .cond       (alm_cond[a]),
        .ack        (alarm_ack),
        .shown_q    (latch_shown[a]),
        .wait_ack_q (alarm_unacked[a])
      );
    end
  endgenerate

  // ***********************************
  // master-slave link alarm
  // ***********************************
  // link loss detect
  assign link_cond = ms_enabled && ms_initialised && (ms_slave_lost || ms_slave_uninit);

  // cleared by disable or reinit only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_alarm_q <= 1'b0;
    end else if (!ms_enabled || ms_reinit) begin
      link_alarm_q <= 1'b0;
    end else if (link_cond) begin
      link_alarm_q <= 1'b1;
    end
  end

  assign alarm_shown = {link_alarm_q, latch_shown};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      analog_alarm_q <= 1'b0;
    end else begin
      analog_alarm_q <= latch_shown[ALM_OVP] || latch_shown[ALM_OTMP];
    end
  end

  // ***********************************
  // user events
  // ***********************************
  generate
    for (genvar k = 0; k < NUM_EVT; k++) begin : g_evt
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          evt_hit_q[k] <= 1'b0;
        end else if (!dc_input_on_q) begin
          evt_hit_q[k] <= 1'b0;
        end else if (meas_valid) begin
          evt_hit_q[k] <= (evt_act_q[k] != PSE_ACT_NONE) &&
                          evt_cmp(k, meas_voltage, meas_current, meas_power, evt_thr_q[k]);
        end
      end
      assign evt_any_hit[k]  = evt_hit_q[k] && (evt_act_q[k] != PSE_ACT_NONE);
      assign evt_warn_hit[k] = evt_hit_q[k] && (evt_act_q[k] == PSE_ACT_WARNING);
      assign evt_alm_hit[k]  = evt_hit_q[k] && (evt_act_q[k] == PSE_ACT_ALARM);
    end
  endgenerate

  // action indications, set wins over ack
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_msg_q       <= '0;
      warning_ind_q   <= 1'b0;
      evt_alarm_ind_q <= 1'b0;
    end else begin
      evt_msg_q       <= (evt_msg_q & ~{NUM_EVT{alarm_ack}}) | evt_any_hit;
      warning_ind_q   <= (warning_ind_q && !alarm_ack) || (|evt_warn_hit);
      evt_alarm_ind_q <= (evt_alarm_ind_q && !alarm_ack) || (|evt_alm_hit);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      beep_q <= 1'b0;
    end else begin
      beep_q <= sound_enable && ((|alarm_unacked) || link_alarm_q || evt_alarm_ind_q);
    end
  end

  // ***********************************
  // dc input switch
  // ***********************************
  // event alarm trips too
  assign trip = (|alm_cond) || link_cond || link_alarm_q || (|evt_alm_hit);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dc_input_on_q <= 1'b0;
    end else if (trip || dc_off_req) begin
      dc_input_on_q <= 1'b0;
    end else if (dc_on_req) begin
      dc_input_on_q <= 1'b1;
    end
  end

  // ***********************************
  // profile save and load
  // ***********************************
  assign mem_we    = (pf_state_q == PSE_PF_SAVE);
  assign mem_waddr = MEM_AW'(prof_base(pf_idx_q) + MEM_AW'(pf_step_q));
  assign mem_wdata = {evt_act_q[pf_step_q], evt_thr_q[pf_step_q]};
  assign mem_raddr = MEM_AW'(prof_base(pf_idx_q) + MEM_AW'(pf_step_q));
  assign load_slot = pf_step_q - 3'h1;

  pse_profile_mem u_mem (
    .clk     (clk),
    .arst_n  (arst_n),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata_q (mem_rdata_q)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pf_state_q     <= PSE_PF_IDLE;
      pf_step_q      <= '0;
      pf_idx_q       <= PROF_DEFAULT;
      profile_busy_q <= 1'b0;
    end else begin
      case (pf_state_q)
        PSE_PF_IDLE: begin
          pf_step_q <= '0;
          pf_idx_q  <= profile_idx;
          if (profile_save && profile_idx != PROF_DEFAULT && profile_idx <= PROF_LAST) begin
            pf_state_q     <= PSE_PF_SAVE;
            profile_busy_q <= 1'b1;
          end else if (profile_load && profile_idx != PROF_DEFAULT && profile_idx <= PROF_LAST) begin
            pf_state_q     <= PSE_PF_LOAD;
            profile_busy_q <= 1'b1;
          end
        end
        PSE_PF_SAVE: begin
          pf_step_q <= pf_step_q + 3'h1;
          if (pf_step_q == STEP_LAST) begin
            pf_state_q     <= PSE_PF_IDLE;
            profile_busy_q <= 1'b0;
          end
        end
        PSE_PF_LOAD: begin
          pf_step_q <= pf_step_q + 3'h1;
          if (pf_step_q == STEP_LOAD_END) begin
            pf_state_q     <= PSE_PF_IDLE;
            profile_busy_q <= 1'b0;
          end
        end
        default: begin
          pf_state_q     <= PSE_PF_IDLE;
          profile_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ***********************************
  // configuration
  // ***********************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prot_thr_q[ALM_OVP] <= PROT_MAX_V;
      prot_thr_q[ALM_OCP] <= PROT_MAX_I;
      prot_thr_q[ALM_OPP] <= PROT_MAX_P;
      for (int k = 0; k < NUM_EVT; k++) begin
        evt_thr_q[k] <= EVT_THR_RST;
        evt_act_q[k] <= PSE_ACT_NONE;
      end
    end else if (pf_state_q == PSE_PF_IDLE && profile_load && profile_idx == PROF_DEFAULT) begin
      for (int k = 0; k < NUM_EVT; k++) begin
        evt_thr_q[k] <= EVT_THR_RST;
        evt_act_q[k] <= PSE_ACT_NONE;
      end
    end else if (pf_state_q == PSE_PF_LOAD) begin
      if (pf_step_q != 3'h0) begin
        evt_thr_q[load_slot] <= mem_rdata_q[MEAS_W-1:0];
        evt_act_q[load_slot] <= pse_act_e'(mem_rdata_q[MEM_DW-1:MEAS_W]);
      end
    end else if (cfg_wr && pf_state_q == PSE_PF_IDLE) begin
      case (cfg_sel)
        CFG_SEL_PROT_V: prot_thr_q[ALM_OVP] <= clamp(cfg_value, PROT_MAX_V);
        CFG_SEL_PROT_I: prot_thr_q[ALM_OCP] <= clamp(cfg_value, PROT_MAX_I);
        CFG_SEL_PROT_P: prot_thr_q[ALM_OPP] <= clamp(cfg_value, PROT_MAX_P);
        default: begin
          for (int k = 0; k < NUM_EVT; k++) begin
            if (cfg_sel == CFG_SEL_EVT0 + 4'(k)) begin
              evt_thr_q[k] <= clamp(cfg_value, evt_limit(k));
              evt_act_q[k] <= pse_act_e'(cfg_action);
            end
          end
        end
      endcase
    end
  end

  // ***********************************
  // checks
  // ***********************************
  chk_prot_trip: assert property (@(posedge clk) disable iff (!arst_n)
    (|alm_cond) |=> !dc_input_on_q) else $error("alarm did not drop input");

  chk_compare_time: assert property (@(posedge clk) disable iff (!arst_n)
    meas_valid && (meas_voltage >= prot_thr_q[ALM_OVP]) |=> prot_hit_q[ALM_OVP])
    else $error("voltage limit not registered");

  chk_link_hold: assert property (@(posedge clk) disable iff (!arst_n)
    link_alarm_q && ms_enabled && !ms_reinit |=> link_alarm_q) else $error("link alarm lost");

  chk_link_raise: assert property (@(posedge clk) disable iff (!arst_n)
    link_cond && !ms_reinit |=> link_alarm_q && !dc_input_on_q) else $error("link loss missed");

  chk_beep_gate: assert property (@(posedge clk) disable iff (!arst_n)
    !sound_enable |=> !beep_q) else $error("sound while disabled");

  chk_evt_off: assert property (@(posedge clk) disable iff (!arst_n)
    !dc_input_on_q |=> evt_hit_q == '0) else $error("event while input off");

  chk_evt_trip: assert property (@(posedge clk) disable iff (!arst_n)
    (|evt_alm_hit) |=> !dc_input_on_q && evt_alarm_ind_q) else $error("event alarm ignored");

endmodule : pse_supervisor

// ### test/pse_dc_source.sv
// behavioural dc source on the load input
`timescale 1ns/1ns
module pse_dc_source
  import pse_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              dc_on,
  input  wire logic [MEAS_W-1:0] src_volt,
  input  wire logic [MEAS_W-1:0] src_curr,
  input  wire logic [MEAS_W-1:0] src_powr,
  output logic                   meas_valid,
  output logic [MEAS_W-1:0]      meas_voltage,
  output logic [MEAS_W-1:0]      meas_current,
  output logic [MEAS_W-1:0]      meas_power
);
  logic [1:0] tick_q;
  // ************************************
  // one sample every fourth cycle
  // ************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_q <= 2'h0;
    end else begin
      tick_q <= tick_q + 2'h1;
    end
  end
  assign meas_valid = (tick_q == 2'h3);
  // bus shows garbage between samples; no current flows while input is off
  assign meas_voltage = meas_valid ? src_volt : ~src_volt;
  assign meas_current = meas_valid ? (dc_on ? src_curr : 16'h0000) : ~src_curr;
  assign meas_power   = meas_valid ? (dc_on ? src_powr : 16'h0000) : ~src_powr;
endmodule : pse_dc_source

// ### test/testbench.sv
// self-checking bench of the protection and event supervisor
`timescale 1ns/1ns
module testbench
  import pse_pkg::*;
;
  logic clk = 1'b0, arst_n = 1'b0, ac_fail = 1'b0, temp_over = 1'b0, ms_enabled = 1'b0;
  logic ms_initialised = 1'b0, ms_slave_lost = 1'b0, ms_slave_uninit = 1'b0, ms_reinit = 1'b0;
  logic alarm_ack = 1'b0, sound_enable = 1'b0, dc_on_req = 1'b0, dc_off_req = 1'b0, cfg_wr = 1'b0;
  logic profile_save = 1'b0, profile_load = 1'b0;
  logic [2:0]  profile_idx = 3'h0;
  logic [3:0]  cfg_sel = 4'h0;
  logic [1:0]  cfg_action = 2'h0;
  logic [15:0] cfg_value = 16'h0000, src_v = 16'h0000, src_i = 16'h0000, src_p = 16'h0000;
  logic meas_valid, dc_q, analog_q, warn_q, ealm_q, beep_q, busy_q;
  logic [15:0] meas_v, meas_i, meas_p;
  logic [5:0]  shown;
  logic [4:0]  unack, hit_q, msg_q;
  int n_mismatch = 0;
  int checks_done = 0;

  always #50 clk = ~clk;

  pse_dc_source src (.clk(clk), .arst_n(arst_n), .dc_on(dc_q), .src_volt(src_v), .src_curr(src_i),
    .src_powr(src_p), .meas_valid(meas_valid), .meas_voltage(meas_v), .meas_current(meas_i),
    .meas_power(meas_p));

  pse_supervisor uut (.clk(clk), .arst_n(arst_n), .meas_valid(meas_valid), .meas_voltage(meas_v),
    .meas_current(meas_i), .meas_power(meas_p), .ac_fail(ac_fail), .temp_over(temp_over),
    .ms_enabled(ms_enabled), .ms_initialised(ms_initialised), .ms_slave_lost(ms_slave_lost),
    .ms_slave_uninit(ms_slave_uninit), .ms_reinit(ms_reinit), .alarm_ack(alarm_ack),
    .sound_enable(sound_enable), .dc_on_req(dc_on_req), .dc_off_req(dc_off_req), .cfg_wr(cfg_wr),
    .cfg_sel(cfg_sel), .cfg_value(cfg_value), .cfg_action(cfg_action), .profile_save(profile_save),
    .profile_load(profile_load), .profile_idx(profile_idx), .dc_input_on_q(dc_q),
    .alarm_shown(shown), .alarm_unacked(unack), .analog_alarm_q(analog_q), .evt_hit_q(hit_q),
    .evt_msg_q(msg_q), .warning_ind_q(warn_q), .evt_alarm_ind_q(ealm_q), .beep_q(beep_q),
    .profile_busy_q(busy_q));

  // ************************************
  // shared tasks
  // ************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask : pulse

  task automatic power_on;
    pulse(dc_on_req);
    chk("dc_on", 16'(dc_q), 16'h0001);
  endtask : power_on

  task automatic wait_trip;
    int n;
    n = 0;
    while (dc_q !== 1'b0 && n < 20) begin
      cyc(1);
      n++;
    end
    if (n == 20) begin
      n_mismatch++;
      $display("Error dc_trip expected 0 seen %b", dc_q);
      stop_test();
    end
  endtask : wait_trip

  task automatic cfg(input logic [3:0] sel, input logic [15:0] val, input logic [1:0] act);
    cfg_sel = sel;
    cfg_value = val;
    cfg_action = act;
    pulse(cfg_wr);
  endtask : cfg

  // ************************************
  // scenarios
  // ************************************
  task automatic s_protect;
    for (int k = 0; k < 3; k++) begin
      power_on();
      src_v = (k == 0) ? 16'h2af7 : 16'h0064;
      src_i = (k == 1) ? 16'h2af7 : 16'h0064;
      src_p = (k == 2) ? 16'h2af7 : 16'h0064;
      cyc(8);
      chk("prot_below", 16'(shown), 16'h0000);
      src_v = (k == 0) ? 16'h2af8 : 16'h0064;
      src_i = (k == 1) ? 16'h2af8 : 16'h0064;
      src_p = (k == 2) ? 16'h2af8 : 16'h0064;
      wait_trip();
      cyc(2);
      chk("prot_shown", 16'(shown), 16'(1 << k));
      chk("analog", 16'(analog_q), 16'(k == 0));
      src_v = 16'h0064;
      src_i = 16'h0064;
      src_p = 16'h0064;
      cyc(8);
      chk("prot_unack", 16'(unack), 16'(1 << k));
      pulse(alarm_ack);
      cyc(1);
      chk("prot_clear", 16'(shown), 16'h0000);
    end
  endtask : s_protect

  task automatic s_hw_alarm;
    for (int k = 3; k < 5; k++) begin
      power_on();
      {temp_over, ac_fail} = (k == 3) ? 2'b01 : 2'b10;
      wait_trip();
      cyc(2);
      chk("hw_shown", 16'(shown), 16'(1 << k));
      chk("analog", 16'(analog_q), 16'(k == 4));
      pulse(alarm_ack);
      chk("ack_held", 16'({shown[k], unack[k]}), 16'h0002);
      {temp_over, ac_fail} = 2'b00;
      cyc(2);
      chk("reack", 16'({shown[k], unack[k]}), 16'h0003);
      pulse(alarm_ack);
      chk("hw_clear", 16'(shown), 16'h0000);
    end
  endtask : s_hw_alarm

  task automatic s_link;
    power_on();
    {ms_enabled, ms_initialised, ms_slave_lost} = 3'b111;
    wait_trip();
    cyc(1);
    chk("link_set", 16'(shown[5]), 16'h0001);
    ms_slave_lost = 1'b0;
    pulse(alarm_ack);
    cyc(2);
    chk("link_ack", 16'(shown[5]), 16'h0001);
    pulse(ms_reinit);
    chk("link_reinit", 16'(shown[5]), 16'h0000);
    ms_slave_uninit = 1'b1;
    cyc(2);
    chk("link_uninit", 16'({shown[5], dc_q}), 16'h0002);
    ms_enabled = 1'b0;
    cyc(2);
    chk("link_off", 16'(shown[5]), 16'h0000);
    ms_slave_uninit = 1'b0;
  endtask : s_link

  task automatic s_event;
    src_v = 16'h1770;
    src_i = 16'h0064;
    power_on();
    cyc(8);
    chk("evt_reset", 16'(hit_q), 16'h0000);
    cfg(CFG_SEL_EVT0, 16'h1388, 2'(PSE_ACT_ALARM));
    cfg(CFG_SEL_EVT0 + 4'h3, 16'h0032, 2'(PSE_ACT_WARNING));
    sound_enable = 1'b1;
    cyc(8);
    chk("warn", 16'({warn_q, ealm_q, dc_q}), 16'h0005);
    src_v = 16'h0fa0;
    wait_trip();
    cyc(2);
    chk("evt_alarm", 16'({msg_q[0], ealm_q, beep_q}), 16'h0007);
    chk("evt_off", 16'(hit_q), 16'h0000);
    sound_enable = 1'b0;
    pulse(alarm_ack);
    chk("evt_ack", 16'({ealm_q, beep_q, warn_q}), 16'h0000);
  endtask : s_event

  task automatic s_profile;
    profile_idx = PROF_DEFAULT;
    pulse(profile_load);
    cfg(CFG_SEL_EVT0 + 4'h1, 16'h0100, 2'(PSE_ACT_SIGNAL));
    profile_idx = PROF_LAST;
    pulse(profile_save);
    chk("prof_busy", 16'(busy_q), 16'h0001);
    cyc(6);
    profile_idx = PROF_DEFAULT;
    pulse(profile_load);
    power_on();
    cyc(8);
    chk("prof_default", 16'({msg_q, busy_q}), 16'h0000);
    profile_idx = PROF_LAST;
    pulse(profile_load);
    cyc(10);
    chk("prof_loaded", 16'({msg_q, warn_q, dc_q}), 16'h0009);
  endtask : s_profile

  initial begin
    cyc(20);
    arst_n = 1'b1;
    cyc(1);
    chk("rst_out", 16'({shown, dc_q, hit_q}), 16'h0000);
    s_protect();
    s_hw_alarm();
    s_link();
    s_event();
    s_profile();
    stop_test();
  end
endmodule : testbench
